// ==== rtps_consts.svh ====
// Purpose: Constants for the radio transmit power sequencer
// Assumes: 10 MHz clock (100 ns period)
// Notes:   Delays in ns, cycle counts derived from the clock period
`ifndef RTPS_CONSTS_SVH
`define RTPS_CONSTS_SVH

`define RTPS_CLK_PERIOD_NS   100
`define RTPS_TOL_NS          100
// Select edge to antenna switch edge (0.1 us)
`define RTPS_D_SEL_SW_NS     100
// Switch to transmit enable (3 us)
`define RTPS_D_SW_TXEN_NS    3000
// Transmit enable to amplifier enable (1 us)
`define RTPS_D_TXEN_PA_NS    1000
// Amplifier off to switch receive (1 us)
`define RTPS_D_PA_SW_NS      1000
// Switch receive to select high (3 us)
`define RTPS_D_SW_SEL_NS     3000
`define RTPS_CYC(ns) (((ns) + `RTPS_CLK_PERIOD_NS - 1) / `RTPS_CLK_PERIOD_NS)
`define RTPS_C_SEL_SW        `RTPS_CYC(`RTPS_D_SEL_SW_NS)
`define RTPS_C_SW_TXEN       `RTPS_CYC(`RTPS_D_SW_TXEN_NS)
`define RTPS_C_TXEN_PA       `RTPS_CYC(`RTPS_D_TXEN_PA_NS)
`define RTPS_C_PA_SW         `RTPS_CYC(`RTPS_D_PA_SW_NS)
`define RTPS_C_SW_SEL        `RTPS_CYC(`RTPS_D_SW_SEL_NS)
`define RTPS_CNT_W           6

`endif

// ==== rtps_pkg.sv ====
// Purpose: Types for the radio transmit power sequencer
// Assumes: Used with rtps_consts.svh
// Notes:   Front-end controls travel as one packed struct
package rtps_pkg;
   typedef enum logic [2:0] {
      RTPS_RX      = 3'b000,
      RTPS_SEL_TX  = 3'b001,
      RTPS_SW_TX   = 3'b010,
      RTPS_TXEN_ON = 3'b011,
      RTPS_TX_RUN  = 3'b100,
      RTPS_WAIT_RDY= 3'b101,
      RTPS_PA_OFF  = 3'b110,
      RTPS_SW_RX   = 3'b111
   } rtps_state_t;

   typedef struct packed {
      logic radio_power_enable_one;
      logic rx_tx_power_select;
      logic antenna_switch_true;
      logic antenna_switch_inverted;
      logic baseband_transmit_enable;
      logic amplifier_power_enable;
      logic synthesizer_power_enable;
      logic synthesizer_run;
   } rtps_front_t;
endpackage

// ==== rtps_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous level inputs
// Assumes: Single clock, active-low asynchronous reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module rtps_sync #(
   parameter int          WIDTH = 1,
   parameter logic [31:0] RESET_VALUE = 32'h0
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   // Shift one stage per clock
   always_comb begin
      next_stage1 = async_in;
      next_sync   = stage1;
   end

   // Reset to the idle level to avoid a false event at release
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stage1   <= RESET_VALUE[WIDTH-1:0];
         sync_out <= RESET_VALUE[WIDTH-1:0];
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule

// ==== rtps_sequencer.sv ====
// Purpose: Sequences radio front-end power, antenna switch, amplifier and
//          baseband transmit enable around each packet
// Assumes: 10 MHz clock; request, last-bit and ready inputs are asynchronous
// Notes:   Every output is registered; delays are whole clock cycles
//          Each counter loads one less than its spacing, since the edge
//          that enters a step already counts as its first cycle
//          Line one follows power-down only in receive idle, so a late
//          power-down request cannot cut the front end mid-packet
//          Inputs cost two edges of latency through the synchroniser
//
// Behaviour
// RQ1: Turn-on: select, switch, transmit enable, amplifier
// RQ2: Antenna switch outputs always complementary
// RQ3: Transmit enable starts baseband transmitter
// RQ4: Turn-on spacings 0.1, 3, 1 us
// RQ5: Drop transmit enable on final bit
// RQ6: Then wait for transmit-ready to fall
// RQ7: Shut-down: amplifier, switch, select high
// RQ8: Shut-down spacings 1 and 3 us
// RQ9: Line one static high; select toggles (code drops line one low in receive idle while power-down is set)
// RQ10: Synthesizer runs if enabled and any line
// RQ11: Synthesizer enable low forces synthesizer off
// RQ12: Reset into receive state
`timescale 1ns/100ps
`include "rtps_consts.svh"
module rtps_sequencer (
   // Clock and reset
   input  wire logic                 clock_in,
   input  wire logic                 rstn_in,
   // Control from the MAC side
   input  wire logic                 tx_request_in,
   input  wire logic                 last_bit_sent_in,
   input  wire logic                 power_down_in,
   input  wire logic                 synth_enable_in,
   // Status from the baseband transmitter
   input  wire logic                 baseband_tx_ready_in,
   // Front-end controls
   output rtps_pkg::rtps_front_t     front_out,
   output rtps_pkg::rtps_state_t     state_out,
   output logic                      busy_out
);
   import rtps_pkg::*;

   // Spacings in whole cycles; all fit the counter width
   localparam logic [`RTPS_CNT_W-1:0] C_SEL_SW  = `RTPS_CNT_W'(`RTPS_C_SEL_SW);
   localparam logic [`RTPS_CNT_W-1:0] C_SW_TXEN = `RTPS_CNT_W'(`RTPS_C_SW_TXEN);
   localparam logic [`RTPS_CNT_W-1:0] C_TXEN_PA = `RTPS_CNT_W'(`RTPS_C_TXEN_PA);
   localparam logic [`RTPS_CNT_W-1:0] C_PA_SW   = `RTPS_CNT_W'(`RTPS_C_PA_SW);
   localparam logic [`RTPS_CNT_W-1:0] C_SW_SEL  = `RTPS_CNT_W'(`RTPS_C_SW_SEL);

   // Synchronised copies of the asynchronous inputs
   logic [4:0]             sync_bus;
   logic                   req;
   logic                   last_bit;
   logic                   pdown;
   logic                   synth_en;
   logic                   tx_ready;

   // Sequencing state and interval counter
   rtps_state_t            state;
   rtps_state_t            next_state;
   logic [`RTPS_CNT_W-1:0] cnt;
   logic [`RTPS_CNT_W-1:0] next_cnt;

   // Levels decoded from the next state
   rtps_front_t            next_front;
   logic                   next_busy;
   logic                   one_lvl;
   logic                   select_lvl;
   logic                   sw_tx;
   logic                   txen;
   logic                   pa_en;

   // All control inputs come from outside this clock domain
   rtps_sync #(.WIDTH(5), .RESET_VALUE(32'h0)) u_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .async_in ({tx_request_in, last_bit_sent_in, power_down_in,
                  synth_enable_in, baseband_tx_ready_in}),
      .sync_out (sync_bus)
   );
   // Unpack in the order the inputs were packed
   assign {req, last_bit, pdown, synth_en, tx_ready} = sync_bus;

   // Sequencing state and interval counter
   always_comb begin
      next_state = state;
      next_cnt   = (cnt != '0) ? cnt - `RTPS_CNT_W'(1) : cnt;
      unique case (state)
         RTPS_RX: begin
            // Power-down parks the sequencer in receive idle
            if (req && !pdown) begin
               next_state = RTPS_SEL_TX;       // RQ1
               next_cnt   = C_SEL_SW - `RTPS_CNT_W'(1); // RQ4
            end
         end
         RTPS_SEL_TX: begin
            if (cnt == '0) begin
               next_state = RTPS_SW_TX;        // RQ1
               next_cnt   = C_SW_TXEN - `RTPS_CNT_W'(1); // RQ4
            end
         end
         RTPS_SW_TX: begin
            if (cnt == '0) begin
               next_state = RTPS_TXEN_ON;      // RQ1
               next_cnt   = C_TXEN_PA - `RTPS_CNT_W'(1); // RQ4
            end
         end
         RTPS_TXEN_ON: begin
            // Final bit may arrive before the amplifier is up
            if (last_bit) begin
               next_state = RTPS_WAIT_RDY;     // RQ5
            end else if (cnt == '0) begin
               next_state = RTPS_TX_RUN;       // RQ1
            end
         end
         RTPS_TX_RUN: begin
            if (last_bit) begin
               next_state = RTPS_WAIT_RDY;     // RQ5
            end
         end
         RTPS_WAIT_RDY: begin
            // Ready is synchronised: the amplifier drops three edges after it
            if (!tx_ready) begin
               next_state = RTPS_PA_OFF;       // RQ6 RQ7
               next_cnt   = C_PA_SW - `RTPS_CNT_W'(1); // RQ8
            end
         end
         RTPS_PA_OFF: begin
            // Amplifier is off; let it settle before the switch moves
            if (cnt == '0) begin
               next_state = RTPS_SW_RX;        // RQ7
               next_cnt   = C_SW_SEL - `RTPS_CNT_W'(1); // RQ8
            end
         end
         RTPS_SW_RX: begin
            // Switch is back on receive; select rises last
            if (cnt == '0) begin
               next_state = RTPS_RX;           // RQ7
            end
         end
      endcase
   end

   // Decode control levels from the next state so outputs stay registered
   always_comb begin
      one_lvl    = 1'b1;
      select_lvl = 1'b1;
      sw_tx      = 1'b0;
      txen       = 1'b0;
      pa_en      = 1'b0;
      unique case (next_state)
         RTPS_RX: begin
            one_lvl    = !pdown;               // RQ9
            select_lvl = !pdown;               // RQ9
         end
         RTPS_SEL_TX: begin
            select_lvl = 1'b0;                 // RQ1
         end
         RTPS_SW_TX: begin
            select_lvl = 1'b0;
            sw_tx      = 1'b1;                 // RQ1
         end
         RTPS_TXEN_ON: begin
            select_lvl = 1'b0;
            sw_tx      = 1'b1;
            txen       = 1'b1;                 // RQ3
         end
         RTPS_TX_RUN: begin
            select_lvl = 1'b0;
            sw_tx      = 1'b1;
            txen       = 1'b1;                 // RQ3
            pa_en      = 1'b1;                 // RQ1
         end
         RTPS_WAIT_RDY: begin
            select_lvl = 1'b0;
            sw_tx      = 1'b1;
            // Keep what the amplifier showed on entry: on after a full
            // turn-on, still off when the final bit beat it
            pa_en      = front_out.amplifier_power_enable; // RQ6
         end
         RTPS_PA_OFF: begin
            select_lvl = 1'b0;
            sw_tx      = 1'b1;                 // RQ7
         end
         RTPS_SW_RX: begin
            select_lvl = 1'b0;                 // RQ7
         end
      endcase

      // Pack the levels; the inverted switch line is derived from sw_tx, then registered
      next_front.radio_power_enable_one   = one_lvl;     // RQ9
      next_front.rx_tx_power_select       = select_lvl;  // RQ9
      next_front.antenna_switch_true      = sw_tx;       // RQ2
      next_front.antenna_switch_inverted  = !sw_tx;      // RQ2
      next_front.baseband_transmit_enable = txen;        // RQ3
      // Amplifier stays on only until ready is seen low
      next_front.amplifier_power_enable   = pa_en && (next_state != RTPS_WAIT_RDY || tx_ready);
      next_front.synthesizer_power_enable = synth_en;    // RQ11
      next_front.synthesizer_run          = synth_en && (one_lvl || select_lvl); // RQ10
      next_busy = (next_state != RTPS_RX);
   end

   // Register state and all outputs; reset comes up receiving
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         // Synchronisers also reset low, so no request is seen at release
         state     <= RTPS_RX;                 // RQ12
         cnt       <= '0;
         front_out <= '{radio_power_enable_one: 1'b1, rx_tx_power_select: 1'b1,
                        antenna_switch_true: 1'b0, antenna_switch_inverted: 1'b1,
                        baseband_transmit_enable: 1'b0, amplifier_power_enable: 1'b0,
                        synthesizer_power_enable: 1'b0, synthesizer_run: 1'b0}; // RQ12
         state_out <= RTPS_RX;
         busy_out  <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         front_out <= next_front;
         state_out <= next_state;
         busy_out  <= next_busy;
      end
   end
endmodule

// ==== rtps_sequencer_monitor.sv ====
// Purpose: Assertions on the front-end control outputs of the sequencer
// Assumes: One clock domain, reset active low
// Notes:   Spacings are whole 100 ns cycles; inputs pass a two-flop sync
`timescale 1ns/100ps
module rtps_sequencer_monitor (
   // Clock and reset
   input wire logic        clock_in,
   input wire logic        rstn_in,
   // Inputs
   input wire logic        tx_request_in,
   input wire logic        last_bit_sent_in,
   input wire logic        power_down_in,
   input wire logic        synth_enable_in,
   input wire logic        baseband_tx_ready_in,
   // Outputs
   input rtps_pkg::rtps_front_t front_out,
   input rtps_pkg::rtps_state_t state_out,
   input wire logic        busy_out
);
   import rtps_pkg::*;
   logic sel, swt, swi, txe, pa;
   // Short names for the watched lines
   assign sel = front_out.rx_tx_power_select;
   assign swt = front_out.antenna_switch_true;
   assign swi = front_out.antenna_switch_inverted;
   assign txe = front_out.baseband_transmit_enable;
   assign pa  = front_out.amplifier_power_enable;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   // Switch stays on transmit ten cycles after the amplifier drops
   sequence sw_hold_s; swt [*8] ##1 swt [*2] ##1 !swt; endsequence
   // Select stays low thirty cycles after the switch returns
   sequence sel_hold_s; ##29 !sel ##1 sel; endsequence
   switch_pair_a: assert property (swt != swi) else $error("switch pair equal");
   switch_after_sel_a: assert property ($rose(swt) |-> !$past(sel) && $past(sel, 2))
      else $error("switch not one cycle after select");
   txen_spacing_a: assert property ($rose(txe) |-> $past(swt, 30) && !$past(swt, 31))
      else $error("transmit enable spacing wrong");
   pa_spacing_a: assert property ($rose(pa) |-> $past(txe, 10) && !$past(txe, 11))
      else $error("amplifier spacing wrong");
   txen_drop_a: assert property ($rose(last_bit_sent_in) && txe |-> ##[1:3] !txe)
      else $error("transmit enable not dropped");
   pa_wait_a: assert property (pa && !txe && baseband_tx_ready_in |=> pa)
      else $error("amplifier dropped while ready");
   pa_drop_a: assert property ($fell(baseband_tx_ready_in) && pa && !txe |-> ##[1:3] !pa)
      else $error("amplifier not dropped");
   sw_after_pa_a: assert property ($fell(pa) |-> sw_hold_s)
      else $error("switch spacing after amplifier wrong");
   sel_last_a: assert property ($fell(swt) |-> sel_hold_s)
      else $error("select spacing after switch wrong");
   txen_gated_a: assert property (txe |-> swt && !sel && front_out.radio_power_enable_one)
      else $error("transmit enable outside transmit path");
endmodule
bind rtps_sequencer rtps_sequencer_monitor u_mon (.clock_in(clock_in), .rstn_in(rstn_in),
   .tx_request_in(tx_request_in), .last_bit_sent_in(last_bit_sent_in),
   .power_down_in(power_down_in), .synth_enable_in(synth_enable_in),
   .baseband_tx_ready_in(baseband_tx_ready_in), .front_out(front_out),
   .state_out(state_out), .busy_out(busy_out));

// ==== rtps_front_model.sv ====
// Purpose: Baseband transmitter ready behaviour seen by the sequencer
// Assumes: Same clock as the sequencer
// Notes:   Slow mode lingers twenty cycles on the last symbol
`timescale 1ns/100ps
module rtps_front_model (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rstn_in,
   // Control
   input  wire logic txen_in,
   input  wire logic slow_in,
   // Status
   output logic      ready_out
);
   logic [4:0] tail;
   // Ready follows enable, then holds while the last symbol is modulated
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ready_out <= 1'b0;
         tail <= 5'h00;
      end else if (txen_in) begin
         ready_out <= 1'b1;
         tail <= slow_in ? 5'h14 : 5'h01;
      end else if (tail != 5'h00) begin
         tail <= tail - 5'h01;
      end else begin
         ready_out <= 1'b0;
      end
   end
endmodule

// ==== radio_tx_power_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the transmit power sequencer
// Assumes: 10 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   Spacings are judged by the bound monitor
`timescale 1ns/100ps
module radio_tx_power_sequencer_tb_top;
   import rtps_pkg::*;
   logic        clock_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        tx_request_in = 1'b0;
   logic        last_bit_sent_in = 1'b0;
   logic        power_down_in = 1'b0;
   logic        synth_enable_in = 1'b0;
   logic        slow = 1'b0;
   logic        ready;
   rtps_front_t front_out;
   rtps_state_t state_out;
   logic        busy_out;
   int          failures = 0;
   int          comparisons = 0;
   // Clock
   always #50 clock_in = ~clock_in;
   rtps_sequencer uut (.clock_in(clock_in), .rstn_in(rstn_in), .tx_request_in(tx_request_in),
      .last_bit_sent_in(last_bit_sent_in), .power_down_in(power_down_in),
      .synth_enable_in(synth_enable_in), .baseband_tx_ready_in(ready),
      .front_out(front_out), .state_out(state_out), .busy_out(busy_out));
   rtps_front_model fe (.clock_in(clock_in), .rstn_in(rstn_in), .txen_in(front_out[3]),
      .slow_in(slow), .ready_out(ready));
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Line encodings and refusal under power down
   task automatic t_power();
      chk(front_out, 8'hD0);
      chk({4'h0, busy_out, state_out}, {5'h00, RTPS_RX});
      synth_enable_in = 1'b1;
      step(5);
      chk(front_out, 8'hD3);
      power_down_in = 1'b1;
      tx_request_in = 1'b1;
      step(10);
      chk(front_out, 8'h12);
      chk({7'h00, busy_out}, 8'h00);
      tx_request_in = 1'b0;
      step(1);
      power_down_in = 1'b0;
      synth_enable_in = 1'b0;
      step(5);
      chk(front_out, 8'hD0);
      synth_enable_in = 1'b1;
      step(4);
      $display("t_power done");
   endtask
   // One packet; early puts the last bit before the amplifier turns on
   task automatic t_tx(input logic sl, input logic early);
      int   n;
      logic seen;
      seen = 1'b0;
      slow = sl;
      tx_request_in = 1'b1;
      for (n = 0; n < 10 && busy_out !== 1'b1; n++) step(1);
      chk({7'h00, busy_out}, 8'h01);
      tx_request_in = 1'b0;
      step(early ? 35 : 45);
      chk(front_out, early ? 8'hAB : 8'hAF);
      last_bit_sent_in = 1'b1;
      power_down_in = early;
      step(4);
      last_bit_sent_in = 1'b0;
      power_down_in = 1'b0;
      chk({7'h00, front_out.radio_power_enable_one}, 8'h01);
      chk({7'h00, front_out.baseband_transmit_enable}, 8'h00);
      if (sl) chk({7'h00, front_out.amplifier_power_enable}, {7'h00, !early});
      for (n = 0; n < 200 && busy_out !== 1'b0; n++) begin
         seen = seen | front_out.amplifier_power_enable;
         step(1);
      end
      if (early) chk({7'h00, seen}, 8'h00);
      chk(front_out, 8'hD3);
      chk({5'h00, state_out}, {5'h00, RTPS_RX});
      $display("t_tx done");
   endtask
   // Main sequence
   initial begin
      step(5);
      rstn_in = 1'b1;
      step(2);
      t_power();
      t_tx(1'b1, 1'b0);
      t_tx(1'b0, 1'b0);
      t_tx(1'b1, 1'b1);
      print_verdict();
   end
   // Watchdog
   initial begin
      #(100 * 5000);
      failures++;
      print_verdict();
   end
endmodule
